// file: rtl/lls_pkg.sv
// Constants shared by the load latency sampler
`default_nettype none
package lls_pkg;
  localparam logic [11:0] LLS_THRESH_ADDR  = 12'h03f6;
  localparam int          LLS_THRESH_W     = 16;
  localparam logic [15:0] LLS_THRESH_RESET = 16'h0000;
  localparam logic [7:0]  LLS_EVT_SEL      = 8'h0b;
  localparam logic [7:0]  LLS_UMASK        = 8'h10;
  localparam int          LLS_CNT_W        = 48;
  localparam int          LLS_ADDR_W       = 48;
  localparam int          LLS_SRC_W        = 4;
  localparam int          LLS_LAT_W        = 16;
  localparam int          LLS_TAG_W        = 4;
  localparam int          LLS_SLOTS        = 16;
  // Data source codes
  localparam logic [3:0] LLS_SRC_L3_MISS_UNK = 4'h0;
  localparam logic [3:0] LLS_SRC_L1_HIT      = 4'h1;
  localparam logic [3:0] LLS_SRC_FILL_BUF    = 4'h2;
  localparam logic [3:0] LLS_SRC_L2_HIT      = 4'h3;
  localparam logic [3:0] LLS_SRC_L3_NOSNOOP  = 4'h4;
  localparam logic [3:0] LLS_SRC_L3_CLEAN    = 4'h5;
  localparam logic [3:0] LLS_SRC_L3_MODIFIED = 4'h6;
  localparam logic [3:0] LLS_SRC_RESV7       = 4'h7;
  localparam logic [3:0] LLS_SRC_REMOTE_FWD  = 4'h8;
  localparam logic [3:0] LLS_SRC_RESV9       = 4'h9;
  localparam logic [3:0] LLS_SRC_LDRAM_S     = 4'ha;
  localparam logic [3:0] LLS_SRC_RDRAM_S     = 4'hb;
  localparam logic [3:0] LLS_SRC_LDRAM_E     = 4'hc;
  localparam logic [3:0] LLS_SRC_RDRAM_E     = 4'hd;
  localparam logic [3:0] LLS_SRC_IO          = 4'he;
  localparam logic [3:0] LLS_SRC_UNCACHED    = 4'hf;
endpackage
`default_nettype wire

// file: rtl/lls_src_enc.sv
// Data source encoder for load sample records
`timescale 1ns/1ps
`default_nettype none
module lls_src_enc (
  input  wire logic [3:0] raw_src,
  output logic      [3:0] code
);
  // Reserved codes fold to the unknown-miss code so they never leave the block
  wire logic is_resv = (raw_src == lls_pkg::LLS_SRC_RESV7) || (raw_src == lls_pkg::LLS_SRC_RESV9);
  assign code = is_resv ? lls_pkg::LLS_SRC_L3_MISS_UNK : raw_src;
endmodule
`default_nettype wire

// file: rtl/lls_top.sv
// Load latency sampler: measures, counts and samples long loads
`timescale 1ns/1ps
`default_nettype none
module lls_top (
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_q,
  // Counter programming
  input  wire logic        cnt_en,
  input  wire logic [7:0]  evt_sel,
  input  wire logic [7:0]  evt_umask,
  input  wire logic        cnt_load,
  input  wire logic [47:0] cnt_load_val,
  output logic      [47:0] cnt_q,
  // Load pipeline
  input  wire logic        ld_exec,
  input  wire logic [3:0]  ld_exec_tag,
  input  wire logic [47:0] ld_exec_addr,
  input  wire logic        ld_done,
  input  wire logic [3:0]  ld_done_tag,
  input  wire logic [3:0]  ld_done_src,
  // Sample record
  output logic             armed_q,
  output logic             rec_valid_q,
  output logic      [15:0] rec_lat_q,
  output logic      [47:0] rec_addr_q,
  output logic      [3:0]  rec_src_q,
  output logic             perf_monitor_interrupt_q
);
  // Per-load tracking slots, one per pipeline tag
  // Sixteen loads in flight at most; a tag reused before delivery restarts its slot
  logic [15:0] thr_q;
  logic        slot_busy_q [lls_pkg::LLS_SLOTS];
  logic [15:0] slot_lat_q  [lls_pkg::LLS_SLOTS];
  logic [15:0] slot_thr_q  [lls_pkg::LLS_SLOTS];
  logic [47:0] slot_addr_q [lls_pkg::LLS_SLOTS];

  // Saturating increment keeps a huge latency above any threshold below 16'hffff
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // Threshold address decode, shared by the write and the read path
  function automatic logic is_thr_addr(input logic [11:0] a);
    is_thr_addr = (a == lls_pkg::LLS_THRESH_ADDR);
  endfunction

  // Tag decode, shared by the execute and the delivery side
  function automatic logic [15:0] tag_onehot(input logic [3:0] t);
    tag_onehot = 16'h0001 << t;
  endfunction

  // Event decode and qualification
  wire logic        thr_hit     = reg_wr && is_thr_addr(reg_addr);
  wire logic        evt_match   = cnt_en && (evt_sel == lls_pkg::LLS_EVT_SEL)
                                  && (evt_umask == lls_pkg::LLS_UMASK);
  wire logic [15:0] exec_sel    = ld_exec ? tag_onehot(ld_exec_tag) : 16'h0000;
  wire logic [15:0] done_sel    = ld_done ? tag_onehot(ld_done_tag) : 16'h0000;
  wire logic [15:0] done_lat    = slot_lat_q[ld_done_tag];
  wire logic [15:0] done_thr    = slot_thr_q[ld_done_tag];
  wire logic        done_ok     = ld_done && slot_busy_q[ld_done_tag];
  // Unsigned compare; a latency equal to the limit does not count
  wire logic        qualify     = done_ok && evt_match && (done_lat > done_thr);
  wire logic [48:0] cnt_inc     = {1'b0, cnt_q} + 49'h0_0000_0000_0001;
  // A preload in the same cycle replaces the count, so it cannot overflow
  wire logic        overflow    = qualify && !cnt_load && cnt_inc[48];
  // The overflowing load only arms; a later qualifying load is recorded
  wire logic        take_sample = qualify && armed_q && !overflow;
  wire logic [3:0]  enc_src;

  lls_src_enc u_enc (
    .raw_src (ld_done_src),
    .code    (enc_src)
  );

  // Threshold register, single copy for the whole core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr_q <= lls_pkg::LLS_THRESH_RESET;
    end else if (thr_hit) begin
      thr_q <= reg_wdata;
    end
  end

  // Read back threshold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rdata_q <= is_thr_addr(reg_addr) ? thr_q : 16'h0000;
    end
  end

  // Busy flag; execute wins over a delivery to the same tag, so a reused tag is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        slot_busy_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        if (exec_sel[i]) begin
          slot_busy_q[i] <= 1'b1;
        end else if (done_sel[i]) begin
          slot_busy_q[i] <= 1'b0;
        end
      end
    end
  end

  // Latency restarts at execute, then counts each busy cycle until the data arrives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        slot_lat_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        if (exec_sel[i]) begin
          slot_lat_q[i] <= 16'h0000;
        end else if (slot_busy_q[i]) begin
          slot_lat_q[i] <= sat_inc(slot_lat_q[i]);
        end
      end
    end
  end

  // Threshold snapshot at execute; a later write leaves loads in flight alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        slot_thr_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        if (exec_sel[i]) begin
          slot_thr_q[i] <= thr_q;
        end
      end
    end
  end

  // Address snapshot at execute, before the load can overwrite its own base
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        slot_addr_q[i] <= 48'h0000_0000_0000;
      end
    end else begin
      for (int i = 0; i < lls_pkg::LLS_SLOTS; i++) begin
        if (exec_sel[i]) begin
          slot_addr_q[i] <= ld_exec_addr;
        end
      end
    end
  end

  // Counter, with software preload; overflow arms the sampler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 48'h0000_0000_0000;
    end else if (cnt_load) begin
      cnt_q <= cnt_load_val;
    end else if (qualify) begin
      cnt_q <= cnt_inc[47:0];
    end
  end

  // Arm on overflow; the overflowing load itself is not sampled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (overflow) begin
      armed_q <= 1'b1;
    end else if (qualify && armed_q) begin
      armed_q <= 1'b0;
    end
  end

  // Record strobe and interrupt, one-cycle pulses in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rec_valid_q              <= 1'b0;
      perf_monitor_interrupt_q <= 1'b0;
    end else begin
      rec_valid_q              <= take_sample;
      perf_monitor_interrupt_q <= take_sample;
    end
  end

  // Record fields hold until the next record, so software may read them late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rec_lat_q  <= 16'h0000;
      rec_addr_q <= 48'h0000_0000_0000;
      rec_src_q  <= 4'h0;
    end else if (take_sample) begin
      rec_lat_q  <= done_lat;
      rec_addr_q <= slot_addr_q[ld_done_tag];
      rec_src_q  <= enc_src;
    end
  end
endmodule
`default_nettype wire

// file: tb/lls_chk.sv
// Port checker for the load latency sampler
`timescale 1ns/1ps
`default_nettype none
module lls_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        ld_done,
  input wire logic        armed_q,
  input wire logic        rec_valid_q,
  input wire logic [15:0] rec_lat_q,
  input wire logic [3:0]  rec_src_q,
  input wire logic        perf_monitor_interrupt_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Records need an armed sampler and a delivery just before
  a_irq_with_rec: assert property (rec_valid_q == perf_monitor_interrupt_q) else $error("irq");
  a_rec_needs_arm: assert property (rec_valid_q |-> $past(armed_q) && $past(ld_done)) else $error("arm");
  a_arm_holds: assert property (armed_q |=> armed_q || rec_valid_q) else $error("hold");
  a_src_legal: assert property (rec_src_q != 4'h7 && rec_src_q != 4'h9) else $error("src");
  a_fields_hold: assert property (!rec_valid_q |-> $stable(rec_lat_q) && $stable(rec_src_q)) else $error("field");
  // Strictly above a threshold of at least zero, so never zero
  a_lat_nonzero: assert property (rec_valid_q |-> rec_lat_q != 16'h0000) else $error("lat");
  a_rd_unmapped: assert property ($past(reg_addr) != lls_pkg::LLS_THRESH_ADDR |-> reg_rdata_q == 16'h0000)
    else $error("rd");
  a_rd_after_wr: assert property ($past(reg_wr, 2) && $past(reg_addr, 2) == lls_pkg::LLS_THRESH_ADDR
    && $past(reg_addr) == lls_pkg::LLS_THRESH_ADDR && !$past(reg_wr) |-> reg_rdata_q == $past(reg_wdata, 2))
    else $error("wr");
  c_record: cover property (rec_valid_q);
  c_armed: cover property ($rose(armed_q));
  c_write: cover property (reg_wr && reg_addr == lls_pkg::LLS_THRESH_ADDR);
endmodule
bind lls_top lls_chk i_chk (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q, .ld_done, .armed_q,
  .rec_valid_q, .rec_lat_q, .rec_src_q, .perf_monitor_interrupt_q);
`default_nettype wire

// file: tb/lls_ld_model.sv
// Load pipeline model: executes one load, later delivers its data
`timescale 1ns/1ps
`default_nettype none
module lls_ld_model (
  input  wire logic        clk,
  output logic             ld_exec,
  output logic      [3:0]  ld_exec_tag,
  output logic      [47:0] ld_exec_addr,
  output logic             ld_done,
  output logic      [3:0]  ld_done_tag,
  output logic      [3:0]  ld_done_src
);
  initial {ld_exec, ld_exec_tag, ld_exec_addr, ld_done, ld_done_tag, ld_done_src} = '0;
  // Address and source lines released after use show inverted values; tag lines keep their last value
  task automatic issue(input logic [3:0] tag, input logic [47:0] a, input int lat, input logic [3:0] s);
    @(posedge clk) #1;
    {ld_exec, ld_exec_tag, ld_exec_addr} = {1'b1, tag, a};
    @(posedge clk) #1;
    {ld_exec, ld_exec_addr} = {1'b0, ~a};
    repeat (lat) @(posedge clk);
    #1 {ld_done, ld_done_tag, ld_done_src} = {1'b1, tag, s};
    @(posedge clk) #1;
    {ld_done, ld_done_src} = {1'b0, ~s};
  endtask
  // Delivery with no load behind it, as a stray tag from the pipeline
  task automatic deliver(input logic [3:0] tag, input logic [3:0] s);
    @(posedge clk) #1;
    {ld_done, ld_done_tag, ld_done_src} = {1'b1, tag, s};
    @(posedge clk) #1;
    {ld_done, ld_done_src} = {1'b0, ~s};
  endtask
endmodule
`default_nettype wire

// file: tb/lls_top_tb.sv
// Testbench for the load latency sampler
`timescale 1ns/1ps
`default_nettype none
module lls_top_tb;
  logic        clk, rst, reg_wr, cnt_en, cnt_load, ld_exec, ld_done, armed_q, rec_valid_q, perf_monitor_interrupt_q;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, rec_lat_q;
  logic [7:0]  evt_sel, evt_umask;
  logic [47:0] cnt_load_val, cnt_q, ld_exec_addr, rec_addr_q;
  logic [3:0]  ld_exec_tag, ld_done_tag, ld_done_src, rec_src_q;
  int          bad_count, total_checks, n_rec, n_irq;
  lls_top i_dut (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q, .cnt_en, .evt_sel, .evt_umask,
    .cnt_load, .cnt_load_val, .cnt_q, .ld_exec, .ld_exec_tag, .ld_exec_addr, .ld_done, .ld_done_tag,
    .ld_done_src, .armed_q, .rec_valid_q, .rec_lat_q, .rec_addr_q, .rec_src_q, .perf_monitor_interrupt_q);
  lls_ld_model i_ld (.clk, .ld_exec, .ld_exec_tag, .ld_exec_addr, .ld_done, .ld_done_tag, .ld_done_src);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Record and interrupt pulses are one cycle, so count them as they pass
  always @(posedge clk) if (rec_valid_q === 1'b1) n_rec <= n_rec + 1;
  always @(posedge clk) if (perf_monitor_interrupt_q === 1'b1) n_irq <= n_irq + 1;
  task chk(input string nm, input logic [47:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1 reg_wr = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk) #1 reg_addr = a;
    @(posedge clk) #1 chk("rdata", e, reg_rdata_q);
  endtask
  task ld(input int lat, input logic [3:0] s, input logic [47:0] a);
    i_ld.issue(s, a, lat, s);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The tests take about 2,300 cycles; this span of 8,000 cycles allows about three and a half times that
  initial begin
    #400000 bad_count++;
    end_sim();
  end
  initial begin
    {reg_wr, reg_addr, reg_wdata, cnt_en, evt_sel, evt_umask, cnt_load, cnt_load_val} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    rd(lls_pkg::LLS_THRESH_ADDR, 16'h0000);
    wr(lls_pkg::LLS_THRESH_ADDR, 16'h0020);
    wr(12'h03f7, 16'hffff);
    rd(lls_pkg::LLS_THRESH_ADDR, 16'h0020);
    rd(12'h03f7, 16'h0000);
    $display("test registers done");
    {cnt_en, evt_sel, evt_umask} = {1'b1, lls_pkg::LLS_EVT_SEL, 8'h00};
    ld(40, 4'h1, 48'h0);
    chk("cnt_q", 48'h0, cnt_q);
    evt_umask = lls_pkg::LLS_UMASK;
    cnt_en = 1'b0;
    ld(40, 4'h1, 48'h0);
    chk("cnt_q", 48'h0, cnt_q);
    cnt_en = 1'b1;
    ld(32, 4'h1, 48'h0);
    chk("cnt_q", 48'h0, cnt_q);
    ld(33, 4'h1, 48'h0);
    chk("cnt_q", 48'h1, cnt_q);
    i_ld.deliver(4'h1, 4'h1);
    repeat (2) @(posedge clk);
    #1 chk("cnt_q", 48'h1, cnt_q);
    $display("test threshold done");
    for (int s = 0; s < 16; s++) begin
      @(posedge clk) #1 {cnt_load, cnt_load_val} = {1'b1, {48{1'b1}}};
      @(posedge clk) #1 cnt_load = 1'b0;
      ld(33, 4'h2, 48'h0);
      chk("armed_q", 48'h1, armed_q);
      chk("cnt_q", 48'h0, cnt_q);
      ld(32, 4'h2, 48'h0);
      chk("n_rec", 48'(s), 48'(n_rec));
      ld(40 + s, 4'(s), 48'h1234_5678_0000 + 48'(s));
      chk("n_rec", 48'(s + 1), 48'(n_rec));
      chk("n_irq", 48'(s + 1), 48'(n_irq));
      chk("rec_lat_q", 48'(40 + s), rec_lat_q);
      chk("rec_addr_q", 48'h1234_5678_0000 + 48'(s), rec_addr_q);
      chk("rec_src_q", (s == 7 || s == 9) ? 48'h0 : 48'(s), rec_src_q);
      chk("armed_q", 48'h0, armed_q);
    end
    $display("test sampling done");
    end_sim();
  end
endmodule
`default_nettype wire
